// ---- shared/freq_slope_map.svh ----
// constant map of the frequency slope stage: offsets, fields, resets, timing
// assumes a 32-bit AXI4-Lite slave with 8 byte address bits decoded
`ifndef FREQ_SLOPE_MAP_SVH
`define FREQ_SLOPE_MAP_SVH

`define FS_ADDR_W      8
`define FS_OFS_CTRL    8'h00
`define FS_OFS_COND    8'h04
`define FS_OFS_SLOPE   8'h08
`define FS_OFS_RATIO   8'h0c
`define FS_OFS_EXPT    8'h10
`define FS_OFS_REMT    8'h14
`define FS_OFS_CNTS    8'h18
`define FS_OFS_CNTT    8'h1c
`define FS_OFS_CNTB    8'h20
`define FS_OFS_ISTAT   8'h24
`define FS_OFS_IMASK   8'h28
`define FS_OFS_RSEL    8'h2c
`define FS_OFS_RSTAMP  8'h30
`define FS_OFS_REVT    8'h34
`define FS_OFS_RPRE    8'h38
`define FS_OFS_RFLT    8'h3c
`define FS_OFS_RCNT    8'h40

`define FS_CTRL_SEL_LO 0
`define FS_CTRL_SEL_HI 1
`define FS_CTRL_CLR    2
`define FS_SEL_RST     2'h3
`define FS_SEL_ON      0
`define FS_SEL_OFF     1

`define FS_EV_START_ON  0
`define FS_EV_START_OFF 1
`define FS_EV_TRIP_ON   2
`define FS_EV_TRIP_OFF  3
`define FS_EV_BLK_ON    4
`define FS_EV_BLK_OFF   5
`define FS_EV_N         6

`define FS_PROG_CYCLE_MS 5
`define FS_PRETRIG_MS    20
`define FS_PRETRIG_N     ((`FS_PRETRIG_MS) / (`FS_PROG_CYCLE_MS))
`define FS_REC_N         12
`define FS_RESP_OKAY     2'h0
`define FS_RESP_SLVERR   2'h2

`endif

// ---- shared/freq_slope_pkg.sv ----
// types shared by the frequency slope stage and its bench
// values are fixed point: slope 0.001 Hz/s, ratio 0.005 p.u., freq 0.01 Hz, times 5 ms
package freq_slope_pkg;

  typedef enum logic [1:0] {
    COND_NORMAL,
    COND_START,
    COND_TRIP,
    COND_BLOCKED
  } cond_e;

  typedef logic [15:0] slope_t;
  typedef logic [15:0] ratio_t;
  typedef logic [15:0] freq_t;
  typedef logic [18:0] time_t;
  typedef logic signed [19:0] stime_t;
  typedef logic [31:0] stamp_t;
  typedef logic [2:0]  evcode_t;
  typedef logic [2:0]  group_t;

  typedef struct packed {
    slope_t slope;
    ratio_t ratio;
    freq_t  freq;
    time_t  expTime;
    stime_t remTime;
  } meas_s;

  typedef struct packed {
    logic    valid;
    logic    store;
    evcode_t code;
    stamp_t  stamp;
  } event_s;

  typedef struct packed {
    stamp_t  stamp;
    evcode_t code;
    group_t  group;
    slope_t  preSlope;
    freq_t   preFreq;
    slope_t  fltSlope;
    freq_t   fltFreq;
  } record_s;

endpackage

// ---- src/freq_slope_stage.sv ----
// status, blocking, events, counters and fault records of one slope stage
// assumes pick-up and delay logic elsewhere; inputs synchronous to core_clk
// Contract
// - condition is normal, start, trip or blocked
// - report measured slope, 0.001 Hz/s steps
// - report slope to pick-up ratio, 0.005 steps
// - report expected operate time, 5 ms steps
// - report signed remaining time while timing
// - sample blocking input at each cycle start
// - unblocked pick-up gives start, timing begins
// - blocked pick-up gives blocked, no timing
// - blocking drops start, release as reset
// - time-stamp events, store selected kinds only
// - on/off events for start, trip, blocked
// - resettable counters for start, trip, blocked
// - keep twelve newest records, oldest displaced
// - record stamp, event, pre/fault values, group
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "freq_slope_map.svh"

module freq_slope_stage
  import freq_slope_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // protection inputs
  input  wire logic             cycleStart,
  input  wire logic             pickUp,
  input  wire logic             blockIn,
  input  wire logic             delayDone,
  input  wire meas_s            measIn,
  input  wire group_t           settingGroup,
  input  wire stamp_t           timeStamp,
  // protection outputs
  output logic                  startOut,
  output logic                  tripOut,
  output logic                  blockedOut,
  output logic                  timerRun,
  output event_s                eventOut,
  output logic                  irq,
  // axi4-lite slave
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  localparam int PreN = `FS_PRETRIG_N;
  localparam int RecN = `FS_REC_N;

  cond_e             cond_q, cond_d;
  meas_s             meas_q;
  slope_t            histSlope_q [PreN];
  freq_t             histFreq_q  [PreN];
  record_s           rec_q [RecN];
  logic [3:0]        recPtr_q, recSel_q;
  logic [4:0]        recCnt_q, rdSlot;
  logic [5:0]        pend_q, pendNew, pendServe, iStat_q, iMask_q;
  logic [2:0]        serveIdx;
  logic [1:0]        evSel_q;
  logic [15:0]       cntStart_q, cntTrip_q, cntBlk_q;
  logic              cntClr, wrDo, rdDo, rdHit, wrHit;
  logic [31:0]       rdMux;
  logic              startNow, tripNow, blkNow;
  logic              startNew, tripNew, blkNew;
  record_s           rdRec;

  // condition next state, decided only at a program cycle start
  always_comb begin
    cond_d = cond_q;
    if (cycleStart) begin
      if (!pickUp) begin
        cond_d = COND_NORMAL;
      end else if (blockIn) begin
        cond_d = COND_BLOCKED;
      end else if (delayDone && cond_q != COND_NORMAL && cond_q != COND_BLOCKED) begin
        cond_d = COND_TRIP;
      end else if (cond_q == COND_TRIP) begin
        cond_d = COND_TRIP;
      end else begin
        cond_d = COND_START;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cond_q <= COND_NORMAL;
    end else begin
      cond_q <= cond_d;
    end
  end

  // start stays up through trip, as the start of a tripping stage does
  assign startNow = (cond_q == COND_START) || (cond_q == COND_TRIP);
  assign tripNow  = (cond_q == COND_TRIP);
  assign blkNow   = (cond_q == COND_BLOCKED);
  assign startNew = (cond_d == COND_START) || (cond_d == COND_TRIP);
  assign tripNew  = (cond_d == COND_TRIP);
  assign blkNew   = (cond_d == COND_BLOCKED);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      startOut   <= 1'b0;
      tripOut    <= 1'b0;
      blockedOut <= 1'b0;
      timerRun   <= 1'b0;
    end else begin
      startOut   <= startNew;
      tripOut    <= tripNew;
      blockedOut <= blkNew;
      timerRun   <= (cond_d == COND_START);
    end
  end

  // live values, latched once per program cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meas_q <= '0;
    end else if (cycleStart) begin
      meas_q.slope   <= measIn.slope;
      meas_q.ratio   <= measIn.ratio;
      meas_q.freq    <= measIn.freq;
      meas_q.expTime <= measIn.expTime;
      meas_q.remTime <= (cond_d == COND_START) ? measIn.remTime : '0;
    end
  end

  // pre-trigger history, one entry per program cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < PreN; i++) begin
        histSlope_q[i] <= '0;
        histFreq_q[i]  <= '0;
      end
    end else if (cycleStart) begin
      histSlope_q[0] <= measIn.slope;
      histFreq_q[0]  <= measIn.freq;
      for (int i = 1; i < PreN; i++) begin
        histSlope_q[i] <= histSlope_q[i-1];
        histFreq_q[i]  <= histFreq_q[i-1];
      end
    end
  end

  // edge detection of the three flags into pending event bits
  always_comb begin
    pendNew = '0;
    pendNew[`FS_EV_START_ON]  = startNew & ~startNow;
    pendNew[`FS_EV_START_OFF] = ~startNew & startNow;
    pendNew[`FS_EV_TRIP_ON]   = tripNew & ~tripNow;
    pendNew[`FS_EV_TRIP_OFF]  = ~tripNew & tripNow;
    pendNew[`FS_EV_BLK_ON]    = blkNew & ~blkNow;
    pendNew[`FS_EV_BLK_OFF]   = ~blkNew & blkNow;
  end

  // one event leaves per clock, lowest code first
  always_comb begin
    pendServe = '0;
    serveIdx  = '0;
    for (int i = `FS_EV_N - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        serveIdx = 3'(i);
      end
    end
    if (|pend_q) begin
      pendServe[serveIdx] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pendServe) | pendNew;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      eventOut <= '0;
    end else begin
      eventOut.valid <= |pend_q;
      eventOut.code  <= serveIdx;
      eventOut.stamp <= timeStamp;
      eventOut.store <= serveIdx[0] ? evSel_q[`FS_SEL_OFF] : evSel_q[`FS_SEL_ON];
    end
  end

  // cumulative counters; a count arriving with the clear survives as one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cntStart_q <= '0;
      cntTrip_q  <= '0;
      cntBlk_q   <= '0;
    end else begin
      cntStart_q <= (cntClr ? 16'h0000 : cntStart_q) + {15'h0000, pendNew[`FS_EV_START_ON]};
      cntTrip_q  <= (cntClr ? 16'h0000 : cntTrip_q) + {15'h0000, pendNew[`FS_EV_TRIP_ON]};
      cntBlk_q   <= (cntClr ? 16'h0000 : cntBlk_q) + {15'h0000, pendNew[`FS_EV_BLK_ON]};
    end
  end

  // fault records written on the on-event of each state, ring of twelve
  always_ff @(posedge core_clk) begin
    if (reset) begin
      recPtr_q <= '0;
      recCnt_q <= '0;
      for (int i = 0; i < RecN; i++) begin
        rec_q[i] <= '0;
      end
    end else if (pendNew[`FS_EV_START_ON] | pendNew[`FS_EV_TRIP_ON] | pendNew[`FS_EV_BLK_ON]) begin
      rec_q[recPtr_q].stamp    <= timeStamp;
      rec_q[recPtr_q].code     <= pendNew[`FS_EV_TRIP_ON] ? 3'(`FS_EV_TRIP_ON) :
                                  pendNew[`FS_EV_BLK_ON] ? 3'(`FS_EV_BLK_ON) : 3'(`FS_EV_START_ON);
      rec_q[recPtr_q].group    <= settingGroup;
      rec_q[recPtr_q].preSlope <= histSlope_q[PreN-1];
      rec_q[recPtr_q].preFreq  <= histFreq_q[PreN-1];
      rec_q[recPtr_q].fltSlope <= measIn.slope;
      rec_q[recPtr_q].fltFreq  <= measIn.freq;
      recPtr_q <= (recPtr_q == 4'(RecN - 1)) ? 4'h0 : recPtr_q + 4'h1;
      if (recCnt_q != 5'(RecN)) begin
        recCnt_q <= recCnt_q + 5'h01;
      end
    end
  end

  // selector 0 is the newest record
  always_comb begin
    rdSlot = 5'({1'b0, recPtr_q}) + 5'(RecN - 1) - 5'({1'b0, recSel_q});
    if (rdSlot >= 5'(RecN)) begin
      rdSlot = rdSlot - 5'(RecN);
    end
    rdRec = rec_q[rdSlot[3:0]];
  end

  // axi write path: address and data are accepted together
  assign wrDo = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  assign cntClr = wrDo && wrHit && s_axi_awaddr == `FS_OFS_CTRL && s_axi_wstrb[0] && s_axi_wdata[`FS_CTRL_CLR];

  always_comb begin
    unique case (s_axi_awaddr)
      `FS_OFS_CTRL, `FS_OFS_ISTAT, `FS_OFS_IMASK, `FS_OFS_RSEL: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FS_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
      if (wrDo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `FS_RESP_OKAY : `FS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers written by software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      evSel_q  <= `FS_SEL_RST;
      iMask_q  <= '0;
      recSel_q <= '0;
    end else if (wrDo && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == `FS_OFS_CTRL) begin
        evSel_q <= s_axi_wdata[`FS_CTRL_SEL_HI:`FS_CTRL_SEL_LO];
      end
      if (s_axi_awaddr == `FS_OFS_IMASK) begin
        iMask_q <= s_axi_wdata[5:0];
      end
      if (s_axi_awaddr == `FS_OFS_RSEL) begin
        recSel_q <= s_axi_wdata[3:0];
      end
    end
  end

  // sticky event status, write one to clear, a new event wins over its clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      iStat_q <= '0;
    end else if (wrDo && s_axi_wstrb[0] && s_axi_awaddr == `FS_OFS_ISTAT) begin
      iStat_q <= (iStat_q & ~s_axi_wdata[5:0]) | pendNew;
    end else begin
      iStat_q <= iStat_q | pendNew;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(iStat_q & iMask_q);
    end
  end

  // axi read path
  assign rdDo = s_axi_arready & s_axi_arvalid;

  always_comb begin
    rdMux = '0;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      `FS_OFS_CTRL:   rdMux[1:0] = evSel_q;
      `FS_OFS_COND:   rdMux[1:0] = cond_q;
      `FS_OFS_SLOPE:  rdMux[15:0] = meas_q.slope;
      `FS_OFS_RATIO:  rdMux[15:0] = meas_q.ratio;
      `FS_OFS_EXPT:   rdMux[18:0] = meas_q.expTime;
      `FS_OFS_REMT:   rdMux = 32'(signed'(meas_q.remTime));
      `FS_OFS_CNTS:   rdMux[15:0] = cntStart_q;
      `FS_OFS_CNTT:   rdMux[15:0] = cntTrip_q;
      `FS_OFS_CNTB:   rdMux[15:0] = cntBlk_q;
      `FS_OFS_ISTAT:  rdMux[5:0] = iStat_q;
      `FS_OFS_IMASK:  rdMux[5:0] = iMask_q;
      `FS_OFS_RSEL:   rdMux[3:0] = recSel_q;
      `FS_OFS_RSTAMP: rdMux = (recSel_q < recCnt_q[3:0] || recCnt_q == 5'(RecN)) ? rdRec.stamp : '0;
      `FS_OFS_REVT:   rdMux[10:0] = {rdRec.group, 5'h00, rdRec.code};
      `FS_OFS_RPRE:   rdMux = {rdRec.preSlope, rdRec.preFreq};
      `FS_OFS_RFLT:   rdMux = {rdRec.fltSlope, rdRec.fltFreq};
      `FS_OFS_RCNT:   rdMux[4:0] = recCnt_q;
      default:        rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `FS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rdDo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? `FS_RESP_OKAY : `FS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- test/freq_slope_stage_checker.sv ----
// concurrent checks on the status, timer, event and bus-answer ports of the slope stage
// assumes a bind into freq_slope_stage; one clock, synchronous active-high reset
`timescale 1ns/100ps
module freq_slope_stage_checker
  import freq_slope_pkg::*;
(
  // clock and reset
  input wire logic   core_clk,
  input wire logic   reset,
  // protection side
  input wire logic   cycleStart,
  input wire logic   pickUp,
  input wire logic   blockIn,
  input wire logic   delayDone,
  input wire logic   startOut,
  input wire logic   tripOut,
  input wire logic   blockedOut,
  input wire logic   timerRun,
  input wire event_s eventOut,
  // bus answers
  input wire logic   s_axi_bvalid,
  input wire logic   s_axi_bready,
  input wire logic   s_axi_rvalid,
  input wire logic   s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  pick_start_a: assert property (cycleStart && pickUp && !blockIn |=> startOut && !blockedOut)
    else $error("unblocked pick-up gave no start");
  pick_blocked_a: assert property (cycleStart && pickUp && blockIn |=> blockedOut && !startOut && !tripOut)
    else $error("blocked pick-up not reported as blocked");
  drop_normal_a: assert property (cycleStart && !pickUp |=> !startOut && !tripOut && !blockedOut)
    else $error("released pick-up left a status set");
  cycle_hold_a: assert property (!cycleStart |=> $stable({startOut, tripOut, blockedOut, timerRun}))
    else $error("status moved outside a program cycle edge");
  delay_trip_a: assert property (cycleStart && pickUp && !blockIn && delayDone && startOut |=> tripOut)
    else $error("expired delay did not trip");
  timer_run_a: assert property (timerRun == (startOut && !tripOut))
    else $error("timer run differs from start state");
  start_event_a: assert property (cycleStart && pickUp && !blockIn && !startOut && !blockedOut
    |=> ##1 eventOut.valid && eventOut.code == 3'h0)
    else $error("start-on event missing");
  block_event_a: assert property (cycleStart && pickUp && blockIn && startOut && !tripOut
    |=> ##1 (eventOut.valid && eventOut.code == 3'h1) ##1 (eventOut.valid && eventOut.code == 3'h4))
    else $error("blocking a start gave wrong event order");
  resp_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) or (s_axi_rvalid && !s_axi_rready)
    |=> s_axi_bvalid || s_axi_rvalid)
    else $error("bus answer withdrawn before taken");
endmodule

bind freq_slope_stage freq_slope_stage_checker freq_slope_stage_checker_inst (.core_clk, .reset, .cycleStart,
  .pickUp, .blockIn, .delayDone, .startOut, .tripOut, .blockedOut, .timerRun, .eventOut, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// ---- test/slope_relay_model.sv ----
// relay surroundings: program cycle pacing, blocking matrix output and event buffer tallies
// assumes the bench requests blocking levels; one clock, synchronous reset
`timescale 1ns/100ps
module slope_relay_model
  import freq_slope_pkg::*;
(
  // clock and reset
  input wire logic   core_clk,
  input wire logic   reset,
  // blocking request from the bench
  input wire logic   blockReq,
  // stage side
  output logic       cycleStart,
  output logic       blockIn,
  input wire event_s eventOut,
  // event buffer tallies
  output logic [7:0] evCount,
  output logic [7:0] storeCount
);
  logic [3:0] phase_q;

  // 16 clocks a cycle leaves room for the stage to drain its event queue
  always_ff @(posedge core_clk) begin
    phase_q    <= reset ? 4'h0 : phase_q + 4'h1;
    cycleStart <= !reset && phase_q == 4'hf;
  end

  // blocking settles one clock after the request, well ahead of any delay expiry
  always_ff @(posedge core_clk) begin
    blockIn <= !reset && blockReq;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      evCount    <= 8'h0;
      storeCount <= 8'h0;
    end else if (eventOut.valid) begin
      evCount    <= evCount + 8'h1;
      storeCount <= storeCount + {7'h0, eventOut.store};
    end
  end
endmodule

// ---- test/freq_slope_stage_tb.sv ----
// self-checking bench: drives the stage through its bus and protection inputs
// assumes slope_relay_model paces program cycles and blocking
`timescale 1ns/100ps
`include "freq_slope_map.svh"
module freq_slope_stage_tb
  import freq_slope_pkg::*;
;
  logic        core_clk, reset, cycleStart, pickUp, blockIn, blockReq, delayDone, irq;
  logic        startOut, tripOut, blockedOut, timerRun;
  meas_s       measIn;
  group_t      settingGroup;
  stamp_t      timeStamp;
  event_s      eventOut;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, evCount, storeCount;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          failCount, samplesChecked, cycles;

  freq_slope_stage freq_slope_stage_inst (.core_clk, .reset, .cycleStart, .pickUp, .blockIn, .delayDone,
    .measIn, .settingGroup, .timeStamp, .startOut, .tripOut, .blockedOut, .timerRun, .eventOut, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  slope_relay_model slope_relay_model_inst (.core_clk, .reset, .blockReq, .cycleStart, .blockIn, .eventOut,
    .evCount, .storeCount);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (failCount == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // one program cycle edge, then time for the event queue to drain
  task step;
    @(posedge core_clk iff cycleStart);
    repeat (8) @(posedge core_clk);
  endtask

  // the whole run needs under a thousand clocks; a hang is cut well beyond that
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      report_and_stop();
    end
  end

  initial begin
    {reset, pickUp, blockReq, delayDone} = 4'h8;
    measIn = {16'h1234, 16'h00c8, 16'h1388, 19'h00168, 20'hffffc};
    settingGroup = 3'h1;
    timeStamp = 32'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) step();
    rd(`FS_OFS_CTRL, 32'h3);
    rd(`FS_OFS_COND, 32'h0);
    rd(`FS_OFS_RCNT, 32'h0);
    rd(8'h80, 32'h0, `FS_RESP_SLVERR);
    wr(`FS_OFS_COND, 32'h2, `FS_RESP_SLVERR);
    wr(`FS_OFS_CTRL, 32'h1);
    pickUp <= 1'b1;
    step();
    rd(`FS_OFS_COND, 32'h1);
    rd(`FS_OFS_SLOPE, 32'h1234);
    rd(`FS_OFS_RATIO, 32'h00c8);
    rd(`FS_OFS_EXPT, 32'h168);
    rd(`FS_OFS_REMT, 32'hfffffffc);
    rd(`FS_OFS_CNTS, 32'h1);
    rd(`FS_OFS_ISTAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`FS_OFS_IMASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`FS_OFS_ISTAT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    delayDone <= 1'b1;
    step();
    rd(`FS_OFS_COND, 32'h2);
    rd(`FS_OFS_CNTT, 32'h1);
    blockReq <= 1'b1;
    step();
    rd(`FS_OFS_COND, 32'h3);
    rd(`FS_OFS_REMT, 32'h0);
    {pickUp, blockReq, delayDone} <= 3'h0;
    step();
    rd(`FS_OFS_COND, 32'h0);
    {pickUp, blockReq} <= 2'h3;
    timeStamp <= 32'h00000a5c;
    settingGroup <= 3'h5;
    measIn.slope <= 16'h0abc;
    measIn.freq <= 16'h1390;
    step();
    rd(`FS_OFS_COND, 32'h3);
    rd(`FS_OFS_CNTB, 32'h2);
    rd(`FS_OFS_RCNT, 32'h4);
    rd(`FS_OFS_RSTAMP, 32'h00000a5c);
    rd(`FS_OFS_REVT, 32'h504);
    rd(`FS_OFS_RPRE, 32'h12341388);
    rd(`FS_OFS_RFLT, 32'h0abc1390);
    chk({24'h0, evCount}, 32'h7);
    chk({24'h0, storeCount}, 32'h4);
    wr(`FS_OFS_CTRL, 32'h6);
    rd(`FS_OFS_CNTB, 32'h0);
    rd(`FS_OFS_CTRL, 32'h2);
    {pickUp, blockReq} <= 2'h0;
    step();
    for (int i = 0; i < 9; i++) begin
      pickUp <= 1'b1;
      step();
      pickUp <= 1'b0;
      step();
    end
    rd(`FS_OFS_RCNT, 32'hc);
    wr(`FS_OFS_RSEL, 32'hb);
    rd(`FS_OFS_REVT, 32'h102);
    pickUp <= 1'b1;
    step();
    blockReq <= 1'b1;
    step();
    rd(`FS_OFS_COND, 32'h3);
    rd(`FS_OFS_CNTB, 32'h1);
    chk({24'h0, evCount}, 32'h1d);
    chk({24'h0, storeCount}, 32'hf);
    report_and_stop();
  end
endmodule
